// ===== tps_abort_info.sv
// Abort-information word builder
`timescale 1ns/1ps
module tps_abort_info
	import tps_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_txn,
	input  wire logic             txn_begin,
	input  wire logic             txn_commit,
	input  wire logic             txn_abort,
	input  tps_abort_cause_t      cause,
	output logic           [63:0] word
);

	logic [31:0] run_r;
	logic [31:0] run_nxt;
	logic [63:0] word_r;
	logic [63:0] word_nxt;

	assign run_nxt = txn_begin ? 32'h0000_0001 :
	                 in_txn    ? run_r + 32'h0000_0001 : run_r;

	// ==========================================================
	// Word assembly, upper bits forced to zero
	always_comb
	begin
		word_nxt = word_r;
		if (txn_commit || txn_abort)
		begin
			word_nxt                 = '0;
			word_nxt[AI_CYC_MSB:0]   = run_nxt;
		end
		if (txn_abort)
		begin
			word_nxt[AI_ELIDED]    = !cause.restricted;
			word_nxt[AI_RESTRICT]  = cause.restricted;
			word_nxt[AI_INSTR]     = cause.instr_related;
			word_nxt[AI_NON_INSTR] = !cause.instr_related;
			word_nxt[AI_RETRY]     = cause.retry;
			word_nxt[AI_CONFLICT]  = cause.conflict;
			word_nxt[AI_CAP_WR]    = cause.cap_wr;
			word_nxt[AI_CAP_RD]    = cause.cap_rd;
		end
	end

	assign word = word_r;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			run_r  <= CYC_RESET;
			word_r <= '0;
		end
		else
		begin
			run_r  <= run_nxt;
			word_r <= word_nxt;
		end
	end

endmodule : tps_abort_info

// ===== tps_core_model.sv
// Behavioural core model: transactional regions and abort response
`timescale 1ns/1ps
module tps_core_model
	import tps_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       go,
	input  wire logic [7:0] len,
	input  wire logic       do_abort,
	input  wire logic [2:0] delay,
	input  wire logic       abort_req,
	output logic            active,
	output logic            tbegin,
	output logic            tcommit,
	output logic            tabort,
	output logic      [7:0] cyc
);
	logic [2:0] wait_r;
	wire        last     = (cyc + 8'h01 == len);
	// Slow answer: the abort follows a pending request after delay plus one cycles
	wire        force_ab = abort_req && (wait_r == delay);

	// ==========================================================
	// Region sequencing
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			active  <= 1'b0;
			tbegin  <= 1'b0;
			tcommit <= 1'b0;
			tabort  <= 1'b0;
			cyc     <= 8'h00;
			wait_r  <= 3'h0;
		end
		else
		begin
			tbegin  <= go && !active;
			tcommit <= 1'b0;
			tabort  <= 1'b0;
			if (go && !active)
			begin
				active <= 1'b1;
				cyc    <= 8'h01;
				wait_r <= 3'h0;
			end
			else if (tcommit || tabort)
				active <= 1'b0;
			else if (active)
			begin
				cyc     <= cyc + 8'h01;
				wait_r  <= abort_req ? wait_r + 3'h1 : 3'h0;
				tabort  <= force_ab || (last && do_abort);
				tcommit <= last && !do_abort && !force_ab;
			end
		end
	end
endmodule : tps_core_model

// ===== tps_event_filter.sv
// One counter with transactional filtering and abort checkpoint
`timescale 1ns/1ps
module tps_event_filter
	import tps_pkg::*;
#(
	parameter int W = CTR_W
)(
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         cfg_in_txn,
	input  wire logic         cfg_excl,
	input  wire logic         ev,
	input  wire logic         in_txn,
	input  wire logic         txn_begin,
	input  wire logic         txn_abort,
	input  wire logic         wr,
	input  wire logic [W-1:0] wdata,
	output logic      [W-1:0] count,
	output logic              ovf
);

	logic [W-1:0] count_r;
	logic [W-1:0] count_nxt;
	logic [W-1:0] ckpt_r;
	logic         pass;
	logic         restore;

	// ==========================================================
	// Filtering
	assign pass    = ev && (!cfg_in_txn || in_txn);
	assign restore = cfg_excl && txn_abort;
	assign ovf     = pass && !restore && !wr && (&count_r);
	assign count   = count_r;

	assign count_nxt = wr      ? wdata :
	                   restore ? ckpt_r :
	                   pass    ? count_r + W'(1) : count_r;

	// ==========================================================
	// State
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count_r <= '0;
			ckpt_r  <= '0;
		end
		else
		begin
			count_r <= count_nxt;
			if (txn_begin)
				ckpt_r <= wr ? wdata : count_r;
		end
	end

endmodule : tps_event_filter

// ===== tps_pkg.sv
// Shared constants and types for transaction-aware precise sampling
package tps_pkg;

	// ==========================================================
	// Event select layout
	localparam int EVSEL_W         = 64;
	localparam int EVSEL_CODE_LSB  = 0;
	localparam int EVSEL_UMASK_LSB = 8;
	localparam int EVSEL_IN_TXN    = 32;
	localparam int EVSEL_EXCL_ABT  = 33;

	// ==========================================================
	// Counters and pointers
	localparam int NUM_CTR = 4;
	localparam int CTR_W   = 48;
	localparam int IP_W    = 64;

	// ==========================================================
	// Abort event encodings
	localparam logic [7:0] EV_ELIDED_ABORT     = 8'hC8;
	localparam logic [7:0] EV_RESTRICTED_ABORT = 8'hC9;
	localparam logic [7:0] UMASK_ABORTED       = 8'h04;

	// ==========================================================
	// Record field offsets
	localparam logic [11:0] REC_OFF_NEXT_IP = 12'h008;
	localparam logic [11:0] REC_OFF_TRIGGER = 12'h0B0;
	localparam logic [11:0] REC_OFF_ABORT   = 12'h0B8;

	// ==========================================================
	// Abort-information word layout
	localparam int AI_CYC_MSB   = 31;
	localparam int AI_ELIDED    = 32;
	localparam int AI_RESTRICT  = 33;
	localparam int AI_INSTR     = 34;
	localparam int AI_NON_INSTR = 35;
	localparam int AI_RETRY     = 36;
	localparam int AI_CONFLICT  = 37;
	localparam int AI_CAP_WR    = 38;
	localparam int AI_CAP_RD    = 39;
	localparam int AI_RSVD_LSB  = 40;

	localparam logic [31:0] CYC_RESET = 32'h0000_0000;

	typedef struct packed {
		logic restricted;
		logic instr_related;
		logic retry;
		logic conflict;
		logic cap_wr;
		logic cap_rd;
	} tps_abort_cause_t;

	typedef struct packed {
		logic [IP_W-1:0] next_ip;
		logic [IP_W-1:0] trigger_ip;
		logic [63:0]     abort_info;
		logic            abort_only;
	} tps_record_t;

endpackage : tps_pkg

// ===== tps_top.sv
// Transaction-aware counting and precise sample record builder
`timescale 1ns/1ps
module tps_top
	import tps_pkg::*;
#(
	parameter int N  = NUM_CTR,
	parameter int CW = CTR_W
)(
	input  wire logic                          CLK_SYS,
	input  wire logic                          RESET_N,
	input  wire logic [N-1:0][EVSEL_W-1:0]     EVENT_SELECT,
	input  wire logic [N-1:0]                  PRECISE_EN,
	input  wire logic [N-1:0]                  CTR_WR,
	input  wire logic [CW-1:0]                 CTR_WDATA,
	input  wire logic                          RET_VALID,
	input  wire logic [7:0]                    RET_EVT_CODE,
	input  wire logic [7:0]                    RET_EVT_UMASK,
	input  wire logic [IP_W-1:0]               RETIRE_IP,
	input  wire logic [IP_W-1:0]               NEXT_IP,
	input  wire logic                          TXN_ACTIVE,
	input  wire logic                          TXN_BEGIN,
	input  wire logic                          TXN_COMMIT,
	input  wire logic                          TXN_ABORT,
	input  tps_pkg::tps_abort_cause_t          TXN_ABORT_CAUSE,
	input  wire logic [IP_W-1:0]               TXN_RESUME_IP,
	output logic      [N-1:0][CW-1:0]          COUNT,
	output logic                               TXN_ABORT_REQ,
	output logic                               REDIRECT_VALID,
	output logic      [IP_W-1:0]               REDIRECT_IP,
	output logic                               REC_VALID,
	output tps_pkg::tps_record_t               REC
);

	// ==========================================================
	// Types and signals
	typedef enum logic [1:0] {
		S_IDLE,
		S_ABORT_WAIT,
		S_EMIT
	} tps_state_t;

	tps_state_t      state_r;
	tps_state_t      state_nxt;
	logic [IP_W-1:0] next_ip_r;
	logic [IP_W-1:0] next_ip_nxt;
	logic [IP_W-1:0] trig_r;
	logic [IP_W-1:0] trig_nxt;
	logic            abort_only_r;
	logic            abort_only_nxt;
	logic            redir_r;
	logic [IP_W-1:0] redir_ip_r;
	logic [N-1:0]    ev_hit;
	logic [N-1:0]    ovf;
	logic            pend;
	logic [7:0]      abort_code;
	logic [63:0]     ai_word;
	logic            idle;

	// ==========================================================
	// Event decode
	function automatic logic ev_match(
		input logic [EVSEL_W-1:0] sel,
		input logic [7:0]         code,
		input logic [7:0]         umask
	);
		ev_match = (sel[EVSEL_CODE_LSB +: 8] == code)
		        && (sel[EVSEL_UMASK_LSB +: 8] == umask);
	endfunction : ev_match

	// Aborts appear as retired events of their own kind
	assign abort_code = TXN_ABORT_CAUSE.restricted ?
	                    EV_RESTRICTED_ABORT : EV_ELIDED_ABORT;

	// ==========================================================
	// Counters
	generate
		for (genvar i = 0; i < N; i++)
		begin : g_ctr
			assign ev_hit[i] =
				(RET_VALID && ev_match(EVENT_SELECT[i],
				 RET_EVT_CODE, RET_EVT_UMASK))
				|| (TXN_ABORT && ev_match(EVENT_SELECT[i],
				 abort_code, UMASK_ABORTED));

			tps_event_filter #(
				.W (CW)
			) u_flt (
				.clk        (CLK_SYS),
				.rst_n      (RESET_N),
				.cfg_in_txn (EVENT_SELECT[i][EVSEL_IN_TXN]),
				.cfg_excl   (EVENT_SELECT[i][EVSEL_EXCL_ABT]),
				.ev         (ev_hit[i]),
				.in_txn     (TXN_ACTIVE),
				.txn_begin  (TXN_BEGIN),
				.txn_abort  (TXN_ABORT),
				.wr         (CTR_WR[i]),
				.wdata      (CTR_WDATA),
				.count      (COUNT[i]),
				.ovf        (ovf[i])
			);
		end
	endgenerate

	// ==========================================================
	// Abort information
	tps_abort_info u_ai (
		.clk        (CLK_SYS),
		.rst_n      (RESET_N),
		.in_txn     (TXN_ACTIVE),
		.txn_begin  (TXN_BEGIN),
		.txn_commit (TXN_COMMIT),
		.txn_abort  (TXN_ABORT),
		.cause      (TXN_ABORT_CAUSE),
		.word       (ai_word)
	);

	// ==========================================================
	// Sample sequencing
	assign pend = |(ovf & PRECISE_EN);
	assign idle = (state_r == S_IDLE);

	always_comb
	begin
		state_nxt      = state_r;
		next_ip_nxt    = next_ip_r;
		trig_nxt       = trig_r;
		abort_only_nxt = abort_only_r;
		case (state_r)
			S_IDLE:
			begin
				if (pend)
				begin
					trig_nxt       = RETIRE_IP;
					next_ip_nxt    = NEXT_IP;
					abort_only_nxt = 1'b0;
					if (TXN_ABORT)
					begin
						// Abort-event overflow lands after the abort
						next_ip_nxt    = TXN_RESUME_IP;
						abort_only_nxt = 1'b1;
						state_nxt      = S_EMIT;
					end
					else if (TXN_ACTIVE)
						state_nxt = S_ABORT_WAIT;
					else
						state_nxt = S_EMIT;
				end
			end
			S_ABORT_WAIT:
			begin
				if (TXN_ABORT)
				begin
					next_ip_nxt    = TXN_RESUME_IP;
					abort_only_nxt = 1'b1;
					state_nxt      = S_EMIT;
				end
				else if (TXN_COMMIT)
					state_nxt = S_EMIT;
			end
			S_EMIT:
				state_nxt = S_IDLE;
			default:
				state_nxt = S_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			state_r      <= S_IDLE;
			next_ip_r    <= '0;
			trig_r       <= '0;
			abort_only_r <= 1'b0;
		end
		else
		begin
			state_r      <= state_nxt;
			next_ip_r    <= next_ip_nxt;
			trig_r       <= trig_nxt;
			abort_only_r <= abort_only_nxt;
		end
	end

	// ==========================================================
	// Abort redirect
	always_ff @(posedge CLK_SYS or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			redir_r    <= 1'b0;
			redir_ip_r <= '0;
		end
		else
		begin
			redir_r <= TXN_ABORT;
			if (TXN_ABORT)
				redir_ip_r <= TXN_RESUME_IP;
		end
	end

	// ==========================================================
	// Outputs
	assign TXN_ABORT_REQ  = (state_r == S_ABORT_WAIT);
	assign REDIRECT_VALID = redir_r;
	assign REDIRECT_IP    = redir_ip_r;
	assign REC_VALID      = (state_r == S_EMIT);
	assign REC.next_ip    = next_ip_r;
	assign REC.trigger_ip = trig_r;
	assign REC.abort_info = ai_word;
	assign REC.abort_only = abort_only_r;

	// ==========================================================
	// Checks
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RESET_N);

	logic [CW-1:0] hv_ckpt;
	logic          hv_ok;

	always_ff @(posedge CLK_SYS or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			hv_ckpt <= '0;
			hv_ok   <= 1'b0;
		end
		else if (TXN_BEGIN)
		begin
			hv_ckpt <= COUNT[2];
			hv_ok   <= !CTR_WR[2];
		end
		else if (CTR_WR[2])
			hv_ok <= 1'b0;
	end

	sequence s_pend_in_txn;
		idle && pend && TXN_ACTIVE && !TXN_ABORT;
	endsequence

	sequence s_pend_outside;
		idle && pend && !TXN_ACTIVE && !TXN_ABORT;
	endsequence

	sequence s_forced_abort;
		TXN_ABORT_REQ && TXN_ABORT;
	endsequence

	AST_ABORT_REQ: assert property (
		s_pend_in_txn |=> TXN_ABORT_REQ)
		else $error("sample in region did not request abort");

	AST_NO_REC_WHILE_REQ: assert property (
		TXN_ABORT_REQ |-> !REC_VALID)
		else $error("record emitted before region aborted");

	AST_REC_AFTER_ABORT: assert property (
		s_forced_abort |=> REC_VALID && REC.abort_only)
		else $error("abort record missing after abort");

	AST_ABORT_NEXT_IP: assert property (
		s_forced_abort |=> REC.next_ip == $past(TXN_RESUME_IP))
		else $error("abort record next pointer wrong");

	AST_ORDINARY_REC: assert property (
		s_pend_outside |=> REC_VALID && !REC.abort_only
		&& REC.next_ip == $past(NEXT_IP)
		&& REC.trigger_ip == $past(RETIRE_IP))
		else $error("ordinary record fields wrong");

	AST_RSVD_ZERO: assert property (
		REC_VALID |-> REC.abort_info[63:AI_RSVD_LSB] == '0)
		else $error("reserved abort bits not zero");

	AST_ABORT_KIND: assert property (
		TXN_ABORT |=> ai_word[AI_RESTRICT]
		== $past(TXN_ABORT_CAUSE.restricted)
		&& ai_word[AI_ELIDED] != ai_word[AI_RESTRICT])
		else $error("abort kind bits wrong");

	AST_REDIRECT: assert property (
		TXN_ABORT |=> REDIRECT_VALID
		&& REDIRECT_IP == $past(TXN_RESUME_IP))
		else $error("abort redirect missing");

	AST_CTR2_RESTORE: assert property (
		TXN_ABORT && hv_ok && !TXN_BEGIN && !CTR_WR[2]
		&& EVENT_SELECT[2][EVSEL_EXCL_ABT]
		|=> COUNT[2] == $past(hv_ckpt))
		else $error("counter two not restored on abort");

	AST_IN_TXN_ONLY: assert property (
		!TXN_ACTIVE && !TXN_ABORT && !CTR_WR[0]
		&& EVENT_SELECT[0][EVSEL_IN_TXN]
		|=> COUNT[0] == $past(COUNT[0]))
		else $error("counter counted outside region");

	AST_CYCLES: assert property (
		TXN_BEGIN ##1 (TXN_ACTIVE && !TXN_BEGIN
		&& !TXN_COMMIT && !TXN_ABORT) ##1 TXN_COMMIT
		|=> ai_word[AI_CYC_MSB:0] == 32'h0000_0003)
		else $error("region cycle count wrong");

	AST_TRIGGER_IP: assert property (
		idle && pend |=> REC.trigger_ip == $past(RETIRE_IP))
		else $error("trigger pointer not captured");

	AST_INSTR_BITS: assert property (
		TXN_ABORT |=> ai_word[AI_INSTR]
		== $past(TXN_ABORT_CAUSE.instr_related)
		&& ai_word[AI_NON_INSTR] != ai_word[AI_INSTR])
		else $error("instruction abort bits wrong");

	AST_CAUSE_BITS: assert property (
		TXN_ABORT |=> ai_word[AI_CAP_RD:AI_RETRY]
		== $past({TXN_ABORT_CAUSE.cap_rd, TXN_ABORT_CAUSE.cap_wr,
		TXN_ABORT_CAUSE.conflict, TXN_ABORT_CAUSE.retry}))
		else $error("abort cause bits wrong");

	AST_COMMIT_FLAGS: assert property (
		TXN_COMMIT && !TXN_ABORT |=> ai_word[AI_CAP_RD:AI_ELIDED] == '0)
		else $error("abort flags set after commit");

endmodule : tps_top

// ===== tps_top_tb.sv
// Self-checking bench for transaction-aware precise sampling
`timescale 1ns/1ps
module tps_top_tb;
	import tps_pkg::*;
	localparam int         N   = NUM_CTR;
	localparam logic [7:0] EVC = 8'h2A;
	localparam logic [7:0] EVU = 8'h01;
	logic                      CLK_SYS = 1'h0, RESET_N = 1'h0;
	logic [N-1:0][EVSEL_W-1:0] EVENT_SELECT = '0;
	logic [N-1:0]              PRECISE_EN = '0, CTR_WR = '0;
	logic [CTR_W-1:0]          CTR_WDATA = '0;
	logic                      RET_VALID = 1'h0;
	logic [7:0]                RET_EVT_CODE = '0, RET_EVT_UMASK = '0;
	logic [IP_W-1:0]           RETIRE_IP = '0, NEXT_IP = '0;
	logic [IP_W-1:0]           TXN_RESUME_IP = '0, REDIRECT_IP;
	tps_abort_cause_t          TXN_ABORT_CAUSE = '0, c;
	logic                      TXN_ACTIVE, TXN_BEGIN, TXN_COMMIT, TXN_ABORT;
	logic                      TXN_ABORT_REQ, REDIRECT_VALID, REC_VALID;
	logic [N-1:0][CTR_W-1:0]   COUNT;
	tps_record_t               REC;
	logic                      go = 1'h0, do_abort = 1'h0;
	logic [7:0]                len = 8'h02, cyc, last_cyc;
	logic [2:0]                delay = 3'h0;
	logic [CTR_W-1:0]          exp_c [N], chk [N];
	logic [IP_W-1:0]           ip1, ip2;
	integer                    num_errors = 0, checks = 0, seed = 32'h5ac9;

	tps_top #(.N(N), .CW(CTR_W)) u_dut (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
		.EVENT_SELECT(EVENT_SELECT), .PRECISE_EN(PRECISE_EN),
		.CTR_WR(CTR_WR), .CTR_WDATA(CTR_WDATA), .RET_VALID(RET_VALID),
		.RET_EVT_CODE(RET_EVT_CODE), .RET_EVT_UMASK(RET_EVT_UMASK),
		.RETIRE_IP(RETIRE_IP), .NEXT_IP(NEXT_IP), .TXN_ACTIVE(TXN_ACTIVE),
		.TXN_BEGIN(TXN_BEGIN), .TXN_COMMIT(TXN_COMMIT), .TXN_ABORT(TXN_ABORT),
		.TXN_ABORT_CAUSE(TXN_ABORT_CAUSE), .TXN_RESUME_IP(TXN_RESUME_IP),
		.COUNT(COUNT), .TXN_ABORT_REQ(TXN_ABORT_REQ),
		.REDIRECT_VALID(REDIRECT_VALID), .REDIRECT_IP(REDIRECT_IP),
		.REC_VALID(REC_VALID), .REC(REC));
	tps_core_model u_core (.clk(CLK_SYS), .rst_n(RESET_N), .go(go),
		.len(len), .do_abort(do_abort), .delay(delay),
		.abort_req(TXN_ABORT_REQ), .active(TXN_ACTIVE), .tbegin(TXN_BEGIN),
		.tcommit(TXN_COMMIT), .tabort(TXN_ABORT), .cyc(cyc));

	initial
	begin
		forever #12.5 CLK_SYS = ~CLK_SYS;
	end

	// ==========================================================
	// Expectation functions and counter model
	function automatic logic hit(input int j);
		logic [EVSEL_W-1:0] s;
		logic [7:0]         ac;
		s   = EVENT_SELECT[j];
		ac  = TXN_ABORT_CAUSE.restricted ? EV_RESTRICTED_ABORT : EV_ELIDED_ABORT;
		hit = ((RET_VALID && RET_EVT_CODE == s[7:0] && RET_EVT_UMASK == s[15:8])
			|| (TXN_ABORT && ac == s[7:0] && UMASK_ABORTED == s[15:8]))
			&& (!s[EVSEL_IN_TXN] || TXN_ACTIVE);
	endfunction : hit

	function automatic logic [63:0] aword(input logic [7:0] n,
		input tps_abort_cause_t a);
		aword = {24'h00_0000, a.cap_rd, a.cap_wr, a.conflict, a.retry,
			!a.instr_related, a.instr_related, a.restricted, !a.restricted,
			24'h00_0000, n};
	endfunction : aword

	function automatic logic [EVSEL_W-1:0] sel(input logic in_t,
		input logic ex, input logic [7:0] cd, input logic [7:0] um);
		sel                 = '0;
		sel[7:0]            = cd;
		sel[15:8]           = um;
		sel[EVSEL_IN_TXN]   = in_t;
		sel[EVSEL_EXCL_ABT] = ex;
	endfunction : sel

	always @(posedge CLK_SYS)
	begin
		if (TXN_ABORT)
			last_cyc = cyc;
		for (int j = 0; j < N; j++)
		begin
			if (TXN_BEGIN)
				chk[j] = CTR_WR[j] ? CTR_WDATA : exp_c[j];
			if (!RESET_N || CTR_WR[j])
				exp_c[j] = RESET_N ? CTR_WDATA : '0;
			else if (TXN_ABORT && EVENT_SELECT[j][EVSEL_EXCL_ABT])
				exp_c[j] = chk[j];
			else if (hit(j))
				exp_c[j] = exp_c[j] + 1;
		end
	end

	// ==========================================================
	// Tasks
	task automatic tick(input int n);
		repeat (n) @(posedge CLK_SYS);
	endtask : tick

	task automatic check(input string what, input logic [63:0] e,
		input logic [63:0] g);
		checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask : check

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test

	task automatic wait_rec();
		int t;
		t = 0;
		#1;
		while (REC_VALID !== 1'b1 && t < 100)
		begin
			@(posedge CLK_SYS);
			#1;
			t++;
		end
		if (REC_VALID !== 1'b1)
		begin
			num_errors++;
			$display("MISMATCH REC_VALID expected 1 seen timeout");
			stop_test();
		end
	endtask : wait_rec

	task automatic region(input logic [7:0] l, input logic ab,
		input logic [2:0] d, input tps_abort_cause_t a);
		tick(1);
		go              <= 1'b1;
		len             <= l;
		do_abort        <= ab;
		delay           <= d;
		TXN_ABORT_CAUSE <= a;
		TXN_RESUME_IP   <= {$random(seed), $random(seed)};
		tick(1);
		go <= 1'b0;
	endtask : region

	task automatic traffic(input int n);
		repeat (n)
		begin
			tick(1);
			RET_VALID     <= 1'($random(seed));
			RET_EVT_CODE  <= 1'($random(seed)) ? EVC : 8'h11;
			RET_EVT_UMASK <= EVU;
		end
		tick(1);
		RET_VALID <= 1'b0;
	endtask : traffic

	task automatic one_event(input int pre);
		tick(1);
		ip1          = {$random(seed), $random(seed)};
		ip2          = {$random(seed), $random(seed)};
		CTR_WR       <= 4'h0;
		RET_VALID    <= 1'b1;
		RET_EVT_CODE <= EVC;
		RETIRE_IP    <= ip1;
		NEXT_IP      <= ip2;
		tick(1);
		RET_VALID <= 1'b0;
	endtask : one_event

	// ==========================================================
	// Main sequence
	initial
	begin
		tick(4);
		RESET_N <= 1'b1;
		#1;
		check("COUNT", '0, COUNT[1]);
		check("TXN_ABORT_REQ", '0, TXN_ABORT_REQ);
		$display("test reset done");
		// Filters advertised as supported; exclude only on counter two
		tick(1);
		EVENT_SELECT[0] <= sel(1'b1, 1'b0, EVC, EVU);
		EVENT_SELECT[1] <= sel(1'b0, 1'b0, EVC, EVU);
		EVENT_SELECT[2] <= sel(1'b0, 1'b1, EVC, EVU);
		EVENT_SELECT[3] <= sel(1'b0, 1'b0, EV_ELIDED_ABORT, UMASK_ABORTED);
		traffic(20);
		for (int r = 0; r < 4; r++)
		begin
			c = tps_abort_cause_t'(6'($random(seed)));
			region(r[1] ? 8'h03 : 8'h0C, r[0], 3'h0, c);
			traffic(16);
		end
		tick(4);
		#1;
		check("COUNT0", exp_c[0], COUNT[0]);
		check("COUNT1", exp_c[1], COUNT[1]);
		check("COUNT2", exp_c[2], COUNT[2]);
		check("COUNT3", exp_c[3], COUNT[3]);
		$display("test filters done");
		c = '0;
		region(8'h05, 1'b0, 3'h0, c);
		tick(8);
		PRECISE_EN <= 4'h2;
		CTR_WR     <= 4'h2;
		CTR_WDATA  <= '1;
		one_event(0);
		wait_rec();
		check("trigger_ip", ip1, REC.trigger_ip);
		check("next_ip", ip2, REC.next_ip);
		check("abort_only", '0, REC.abort_only);
		check("abort_info", 64'h0000_0000_0000_0005, REC.abort_info);
		$display("test ordinary record done");
		tick(1);
		CTR_WR <= 4'h2;
		c      = tps_abort_cause_t'(6'($random(seed)));
		region(8'h3C, 1'b0, 3'h3, c);
		one_event(0);
		tick(1);
		#1;
		check("TXN_ABORT_REQ", 1'b1, TXN_ABORT_REQ);
		wait_rec();
		check("abort_only", 1'b1, REC.abort_only);
		check("trigger_ip", ip1, REC.trigger_ip);
		check("next_ip", TXN_RESUME_IP, REC.next_ip);
		check("abort_info", aword(last_cyc, c), REC.abort_info);
		check("REDIRECT_VALID", 1'b1, REDIRECT_VALID);
		check("REDIRECT_IP", TXN_RESUME_IP, REDIRECT_IP);
		$display("test abort inside region done");
		for (int k = 0; k < 2; k++)
		begin
			tick(4);
			EVENT_SELECT[3] <= sel(1'b0, 1'b0, k[0] ? EV_RESTRICTED_ABORT :
				EV_ELIDED_ABORT, UMASK_ABORTED);
			PRECISE_EN <= 4'h8;
			CTR_WR     <= 4'h8;
			tick(1);
			CTR_WR       <= 4'h0;
			c            = tps_abort_cause_t'(6'($random(seed)));
			c.restricted = k[0];
			region(8'h06, 1'b1, 3'h0, c);
			wait_rec();
			check("abort_only", 1'b1, REC.abort_only);
			check("next_ip", TXN_RESUME_IP, REC.next_ip);
			check("trigger_ip", RETIRE_IP, REC.trigger_ip);
			check("abort_info", aword(8'h06, c), REC.abort_info);
		end
		$display("test abort event records done");
		stop_test();
	end
endmodule : tps_top_tb
